/* File: pkg/dtc_pkg.sv */
package dtc_pkg;

    // special function register addresses
    localparam logic [7:0] ADDR_CTL  = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_LO0  = 8'h8A;
    localparam logic [7:0] ADDR_LO1  = 8'h8B;
    localparam logic [7:0] ADDR_HI0  = 8'h8C;
    localparam logic [7:0] ADDR_HI1  = 8'h8D;

    // values after reset
    localparam logic [7:0] RST_CTL  = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CNT  = 8'h00;

    // machine cycle: 12 core clock periods, phase 0 is S1P1
    localparam int         MC_PERIODS = 12;
    localparam logic [3:0] PH_LAST    = 4'(MC_PERIODS - 1);
    localparam logic [3:0] PH_SAMPLE  = 4'h9;
    localparam logic [3:0] PH_UPDATE  = 4'h4;

    // mode register bit positions
    localparam int MB_GATE1 = 7;
    localparam int MB_SRC1  = 6;
    localparam int MB_MHI1  = 5;
    localparam int MB_MLO1  = 4;
    localparam int MB_GATE0 = 3;
    localparam int MB_SRC0  = 2;
    localparam int MB_MHI0  = 1;
    localparam int MB_MLO0  = 0;

    // control register bit positions
    localparam int CB_OVF1 = 7;
    localparam int CB_RUN1 = 6;
    localparam int CB_OVF0 = 5;
    localparam int CB_RUN0 = 4;

    typedef enum logic [1:0] {
        DTC_M13,
        DTC_M16,
        DTC_MRLD,
        DTC_MSPLIT
    } dtc_mode_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic       ovf;
    } dtc_cnt_t;

    typedef struct packed {
        logic [3:0]      phase;
        logic [7:0]      mode;
        logic [7:0]      ctl;
        logic [1:0][7:0] lo;
        logic [1:0][7:0] hi;
        logic [1:0]      pin_s1;
        logic [1:0]      pin_s2;
        logic [1:0]      gate_s1;
        logic [1:0]      gate_s2;
        logic [1:0]      smp;
        logic [1:0]      pend;
        logic [1:0]      pulse;
        logic [7:0]      rdata;
    } dtc_state_t;

endpackage

/* File: rtl/dtc_top.sv */
`timescale 1ns/1ps

// Operation
// - timer function increments low byte once per 12-clock machine cycle
// - counter function samples count pin at sample phase, counts high-then-low
// - counted edge becomes visible at update phase of next machine cycle
// - one falling edge takes two machine cycles, max rate clock/24
// - each timer is high and low 8-bit registers, combined per mode
// - mode bit 7 gates timer 1 with its gate pin
// - mode bit 3 gates timer 0 with its gate pin
// - mode bit 6 selects timer 1 counter or timer source
// - mode bit 2 selects timer 0 counter or timer source
// - timer 1 mode field is mode bits 5 and 4
// - timer 0 mode field is mode bits 1 and 0
// - mode 00: 8-bit high counter behind 5-bit low prescaler
// - mode 01: high and low cascaded into one 16-bit counter
// - mode 10: low byte counts, reloads from high byte on overflow
// - mode 11 on timer 1 stops it and holds the count
// - mode 11 on timer 0: low uses timer 0 controls, high uses only the timer 1 run bit
// - mode register at 89H, resets 00H, byte access only
// - control register at 88H, resets 00H, bit addressable
// - overflow sets flag, cleared when processor vectors to the routine
// - control bits 6 and 4 are run controls of timers 1 and 0
// - autoreload leaves the high byte unchanged
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       RESETN_I,
    input  wire logic [7:0] SFR_ADDR_I,
    input  wire logic       SFR_WR_I,
    input  wire logic [7:0] SFR_WDATA_I,
    input  wire logic       SFR_RD_I,
    input  wire logic       SFR_BIT_WR_I,
    input  wire logic [2:0] SFR_BIT_IDX_I,
    input  wire logic       SFR_BIT_VAL_I,
    input  wire logic       COUNT_PIN_ZERO_I,
    input  wire logic       COUNT_PIN_ONE_I,
    input  wire logic       GATE_PIN_ZERO_I,
    input  wire logic       GATE_PIN_ONE_I,
    input  wire logic [1:0] VECTOR_ACK_I,
    output logic      [7:0] SFR_RDATA_O,
    output logic      [1:0] OVF_PULSE_O,
    output logic      [1:0] OVF_FLAG_O
);

    dtc_state_t state_ff;
    dtc_state_t nxt_state;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // one count step of a timer in the given mode
    function automatic dtc_cnt_t step(input logic [1:0] m,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        dtc_cnt_t r;
        r.lo  = lo;
        r.hi  = hi;
        r.ovf = 1'b0;
        case (dtc_mode_t'(m))
            DTC_M13: begin
                // upper three low bits are left alone
                r.lo = {lo[7:5], lo[4:0] + 5'h01};
                if (lo[4:0] == 5'h1F) begin
                    {r.ovf, r.hi} = {1'b0, hi} + 9'h001;
                end
            end
            DTC_M16: begin
                {r.ovf, r.hi, r.lo} = {1'b0, hi, lo} + 17'h00001;
            end
            DTC_MRLD: begin
                {r.ovf, r.lo} = {1'b0, lo} + 9'h001;
                if (r.ovf) begin
                    r.lo = hi;
                end
            end
            default: begin
                {r.ovf, r.lo} = {1'b0, lo} + 9'h001;
            end
        endcase
        return r;
    endfunction

    logic     [1:0] run;
    logic     [1:0] inc;
    logic     [1:0] mset;
    logic     [1:0] ovf;
    logic           upd;
    logic           hi0_ovf;
    logic           split0;
    dtc_cnt_t       r0;
    dtc_cnt_t       r1;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.pulse = 2'b00;
        r0 = '0;
        r1 = '0;
        hi0_ovf = 1'b0;
        ovf = 2'b00;

        // pins from outside pass two flip-flops
        nxt_state.pin_s1  = {COUNT_PIN_ONE_I, COUNT_PIN_ZERO_I};
        nxt_state.pin_s2  = state_ff.pin_s1;
        nxt_state.gate_s1 = {GATE_PIN_ONE_I, GATE_PIN_ZERO_I};
        nxt_state.gate_s2 = state_ff.gate_s1;

        nxt_state.phase = (state_ff.phase == PH_LAST) ? 4'h0 : state_ff.phase + 4'h1;
        upd = state_ff.phase == PH_UPDATE;

        // edge seen at sample phase is applied at next update phase
        if (state_ff.phase == PH_SAMPLE) begin
            nxt_state.smp  = state_ff.pin_s2;
            nxt_state.pend = state_ff.smp & ~state_ff.pin_s2;
        end else if (upd) begin
            nxt_state.pend = 2'b00;
        end

        split0 = state_ff.mode[MB_MHI0:MB_MLO0] == 2'b11;
        mset[0] = state_ff.mode[MB_SRC0];
        mset[1] = state_ff.mode[MB_SRC1];
        run[0] = state_ff.ctl[CB_RUN0] & (~state_ff.mode[MB_GATE0] | state_ff.gate_s2[0]);
        run[1] = state_ff.ctl[CB_RUN1] & (~state_ff.mode[MB_GATE1] | state_ff.gate_s2[1]);
        for (int i = 0; i < 2; i++) begin
            inc[i] = upd & run[i] & (mset[i] ? state_ff.pend[i] : 1'b1);
        end

        // timer 0
        if (inc[0]) begin
            r0 = step(state_ff.mode[MB_MHI0:MB_MLO0], state_ff.lo[0], state_ff.hi[0]);
            nxt_state.lo[0] = r0.lo;
            if (!split0) begin
                nxt_state.hi[0] = r0.hi;
            end
            ovf[0] = r0.ovf;
        end
        // split mode: high byte of timer 0 counts machine cycles on timer 1 run bit
        if (split0 && upd && state_ff.ctl[CB_RUN1]) begin
            {hi0_ovf, nxt_state.hi[0]} = {1'b0, state_ff.hi[0]} + 9'h001;
        end

        // timer 1; in split mode of timer 0 its overflow no longer raises a flag
        if (inc[1] && state_ff.mode[MB_MHI1:MB_MLO1] != 2'b11) begin
            r1 = step(state_ff.mode[MB_MHI1:MB_MLO1], state_ff.lo[1], state_ff.hi[1]);
            nxt_state.lo[1] = r1.lo;
            nxt_state.hi[1] = r1.hi;
        end
        ovf[1] = split0 ? hi0_ovf : r1.ovf;

        // software writes override the count step of the same cycle
        if (SFR_WR_I) begin
            if (hit(SFR_ADDR_I, ADDR_CTL)) begin
                nxt_state.ctl = SFR_WDATA_I;
            end else if (hit(SFR_ADDR_I, ADDR_MODE)) begin
                nxt_state.mode = SFR_WDATA_I;
            end else if (hit(SFR_ADDR_I, ADDR_LO0)) begin
                nxt_state.lo[0] = SFR_WDATA_I;
            end else if (hit(SFR_ADDR_I, ADDR_LO1)) begin
                nxt_state.lo[1] = SFR_WDATA_I;
            end else if (hit(SFR_ADDR_I, ADDR_HI0)) begin
                nxt_state.hi[0] = SFR_WDATA_I;
            end else if (hit(SFR_ADDR_I, ADDR_HI1)) begin
                nxt_state.hi[1] = SFR_WDATA_I;
            end
        end else if (SFR_BIT_WR_I) begin
            nxt_state.ctl[SFR_BIT_IDX_I] = SFR_BIT_VAL_I;
        end

        // vector acknowledge clears, a coincident overflow wins
        if (VECTOR_ACK_I[0]) begin
            nxt_state.ctl[CB_OVF0] = 1'b0;
        end
        if (VECTOR_ACK_I[1]) begin
            nxt_state.ctl[CB_OVF1] = 1'b0;
        end
        if (ovf[0]) begin
            nxt_state.ctl[CB_OVF0] = 1'b1;
        end
        if (ovf[1]) begin
            nxt_state.ctl[CB_OVF1] = 1'b1;
        end
        nxt_state.pulse = ovf;

        // read data is held until the next read; unmapped reads zero
        if (SFR_RD_I) begin
            if (hit(SFR_ADDR_I, ADDR_CTL)) begin
                nxt_state.rdata = state_ff.ctl;
            end else if (hit(SFR_ADDR_I, ADDR_MODE)) begin
                nxt_state.rdata = state_ff.mode;
            end else if (hit(SFR_ADDR_I, ADDR_LO0)) begin
                nxt_state.rdata = state_ff.lo[0];
            end else if (hit(SFR_ADDR_I, ADDR_LO1)) begin
                nxt_state.rdata = state_ff.lo[1];
            end else if (hit(SFR_ADDR_I, ADDR_HI0)) begin
                nxt_state.rdata = state_ff.hi[0];
            end else if (hit(SFR_ADDR_I, ADDR_HI1)) begin
                nxt_state.rdata = state_ff.hi[1];
            end else begin
                nxt_state.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_ff       <= '0;
            state_ff.mode  <= RST_MODE;
            state_ff.ctl   <= RST_CTL;
            state_ff.lo    <= {RST_CNT, RST_CNT};
            state_ff.hi    <= {RST_CNT, RST_CNT};
            state_ff.rdata <= 8'h00;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign SFR_RDATA_O = state_ff.rdata;
    assign OVF_PULSE_O = state_ff.pulse;
    assign OVF_FLAG_O  = {state_ff.ctl[CB_OVF1], state_ff.ctl[CB_OVF0]};

    // checks
    logic any_wr;
    assign any_wr = SFR_WR_I | SFR_BIT_WR_I;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);

    property p_phase_wrap;
        state_ff.phase == PH_LAST |=> state_ff.phase == 4'h0 ##4 state_ff.phase == PH_UPDATE;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("machine cycle not 12 clocks");

    property p_tick16;
        (upd && !any_wr && state_ff.mode[3:0] == 4'h1 && state_ff.ctl[CB_RUN0])
            |=> {state_ff.hi[0], state_ff.lo[0]} == $past({state_ff.hi[0], state_ff.lo[0]}) + 16'h0001;
    endproperty
    a_tick16: assert property (p_tick16) else $error("16-bit timer did not step");

    property p_upd_only;
        ($changed(state_ff.lo[0]) && !$past(any_wr)) |-> $past(state_ff.phase) == PH_UPDATE;
    endproperty
    a_upd_only: assert property (p_upd_only) else $error("count changed off update phase");

    property p_pend_src;
        $rose(state_ff.pend[0]) |-> $past(state_ff.phase) == PH_SAMPLE && $past(state_ff.smp[0]);
    endproperty
    a_pend_src: assert property (p_pend_src) else $error("edge taken off sample phase");

    property p_gate0;
        (upd && !any_wr && state_ff.mode[MB_GATE0] && !state_ff.gate_s2[0] && !split0)
            |=> $stable(state_ff.lo[0]) && $stable(state_ff.hi[0]);
    endproperty
    a_gate0: assert property (p_gate0) else $error("timer 0 counted with gate low");

    property p_gate1;
        (upd && !any_wr && state_ff.mode[MB_GATE1] && !state_ff.gate_s2[1])
            |=> $stable(state_ff.lo[1]) && $stable(state_ff.hi[1]);
    endproperty
    a_gate1: assert property (p_gate1) else $error("timer 1 counted with gate low");

    property p_stop1;
        (!any_wr && state_ff.mode[MB_MHI1:MB_MLO1] == 2'b11) |=> $stable(state_ff.lo[1]);
    endproperty
    a_stop1: assert property (p_stop1) else $error("timer 1 ran in mode 11");

    property p_reload;
        (state_ff.pulse[0] && state_ff.mode[1:0] == 2'b10 && !$past(any_wr))
            |-> state_ff.lo[0] == state_ff.hi[0] && $stable(state_ff.hi[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("autoreload wrong");

    property p_m13;
        (state_ff.pulse[0] && state_ff.mode[1:0] == 2'b00 && !$past(any_wr))
            |-> state_ff.hi[0] == 8'h00 && state_ff.lo[0][4:0] == 5'h00;
    endproperty
    a_m13: assert property (p_m13) else $error("13-bit overflow wrong");

    property p_pulse_flag;
        state_ff.pulse[0] |-> state_ff.ctl[CB_OVF0] ##1 !state_ff.pulse[0];
    endproperty
    a_pulse_flag: assert property (p_pulse_flag) else $error("overflow pulse without flag");

    property p_pulse_flag1;
        state_ff.pulse[1] |-> state_ff.ctl[CB_OVF1] ##1 !state_ff.pulse[1];
    endproperty
    a_pulse_flag1: assert property (p_pulse_flag1) else $error("timer 1 pulse without flag");

    property p_m13_one;
        (state_ff.pulse[1] && state_ff.mode[5:4] == 2'b00 && !split0 && !$past(any_wr))
            |-> state_ff.hi[1] == 8'h00 && state_ff.lo[1][4:0] == 5'h00;
    endproperty
    a_m13_one: assert property (p_m13_one) else $error("timer 1 13-bit overflow wrong");

    // in split mode the timer 1 flag belongs to the high byte of timer 0
    property p_split_hi;
        (state_ff.pulse[1] && split0 && !$past(any_wr))
            |-> state_ff.hi[0] == 8'h00 && state_ff.ctl[CB_OVF1];
    endproperty
    a_split_hi: assert property (p_split_hi) else $error("split high byte overflow wrong");

    property p_ack_clr;
        (VECTOR_ACK_I[0] && !ovf[0] && !any_wr) |=> !state_ff.ctl[CB_OVF0];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("vector did not clear timer 0 flag");

endmodule

/* File: testbench/dtc_pin_model.sv */
`timescale 1ns/1ps

// external count source: idles high, each pulse is a falling edge
module dtc_pin_model (
    input  wire logic clk_i,
    output logic      pin_o
);
    initial pin_o = 1'b1;

    // each level held exactly one machine cycle, the fastest legal rate (clock/24)
    task automatic pulses(input int n);
        repeat (n) begin
            @(negedge clk_i);
            pin_o = 1'b0;
            repeat (12) @(negedge clk_i);
            pin_o = 1'b1;
            repeat (11) @(negedge clk_i);
        end
    endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps

module tb_top
    import dtc_pkg::*;
;
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bwr;
    logic [2:0] bidx;
    logic       bval;
    logic       g0;
    logic       g1;
    logic [1:0] ack;
    wire logic  p0;
    wire logic  p1;
    logic [7:0] rdata;
    logic [1:0] pulse;
    logic [1:0] flag;
    int         failures   = 0;
    int         n_compared = 0;
    int         n;
    logic [7:0] ra [6];

    always #20 clk = ~clk;

    dtc_top dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
        .SFR_WDATA_I(wdata), .SFR_RD_I(rd), .SFR_BIT_WR_I(bwr), .SFR_BIT_IDX_I(bidx),
        .SFR_BIT_VAL_I(bval), .COUNT_PIN_ZERO_I(p0), .COUNT_PIN_ONE_I(p1), .GATE_PIN_ZERO_I(g0),
        .GATE_PIN_ONE_I(g1), .VECTOR_ACK_I(ack), .SFR_RDATA_O(rdata), .OVF_PULSE_O(pulse),
        .OVF_FLAG_O(flag));
    dtc_pin_model pm0 (.clk_i(clk), .pin_o(p0));
    dtc_pin_model pm1 (.clk_i(clk), .pin_o(p1));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic wr_bit(input logic [2:0] i, input logic v);
        @(negedge clk);
        bidx = i;
        bval = v;
        bwr = 1'b1;
        @(negedge clk);
        bwr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk(nm, e, rdata);
    endtask

    // bounded wait; n counts falling edges up to the one that shows the pulse
    task automatic wait_pulse(input int idx, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (pulse[idx] !== 1'b1 && cnt < lim);
        chk("pulse", 8'h01, {7'h00, pulse[idx]});
        @(negedge clk);
        chk("pulse_len", 8'h00, {7'h00, pulse[idx]});
        chk("flag_set", 8'h01, {7'h00, flag[idx]});
    endtask

    task automatic ack_chk(input int idx);
        @(negedge clk);
        ack[idx] = 1'b1;
        @(negedge clk);
        ack = 2'b00;
        chk("flag_clr", 8'h00, {7'h00, flag[idx]});
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 4000);
        failures++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        {addr, wdata, wr, rd, bwr, bidx, bval, g0, g1, ack} = '0;
        ra = '{ADDR_CTL, ADDR_MODE, ADDR_LO0, ADDR_LO1, ADDR_HI0, ADDR_HI1};
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_chk(ra[i], 8'h00, "reset_value");
        end
        wr_b(8'h8E, 8'hFF);
        rd_chk(8'h8E, 8'h00, "unmapped");
        wr_b(ADDR_MODE, 8'hA5);
        rd_chk(ADDR_MODE, 8'hA5, "mode_rw");
        wr_bit(3'h2, 1'b1);
        rd_chk(ADDR_CTL, 8'h04, "ctl_bit");
        wr_bit(3'h2, 1'b0);
        $display("test registers done");
        // autoreload: three steps per overflow, 12 clocks per step
        wr_b(ADDR_MODE, 8'h02);
        wr_b(ADDR_HI0, 8'hFD);
        wr_b(ADDR_LO0, 8'hFD);
        wr_bit(3'h4, 1'b1);
        rd_chk(ADDR_CTL, 8'h10, "run_bit");
        wait_pulse(0, 60, n);
        wait_pulse(0, 60, n);
        chk("reload_period", 8'h23, 8'(n));
        wr_bit(3'h4, 1'b0);
        rd_chk(ADDR_HI0, 8'hFD, "reload_hi");
        ack_chk(0);
        $display("test autoreload done");
        // 16-bit timer: FFFF wraps to 0000 on one machine cycle step
        wr_b(ADDR_MODE, 8'h01);
        wr_b(ADDR_LO0, 8'hFF);
        wr_b(ADDR_HI0, 8'hFF);
        wr_bit(3'h4, 1'b1);
        wait_pulse(0, 20, n);
        wr_bit(3'h4, 1'b0);
        rd_chk(ADDR_LO0, 8'h00, "wrap_lo");
        rd_chk(ADDR_HI0, 8'h00, "wrap_hi");
        ack_chk(0);
        $display("test timer16 done");
        // 13-bit mode: upper three low bits stay put
        wr_b(ADDR_MODE, 8'h00);
        wr_b(ADDR_LO1, 8'hFF);
        wr_b(ADDR_HI1, 8'hFF);
        wr_bit(3'h6, 1'b1);
        wait_pulse(1, 20, n);
        wr_bit(3'h6, 1'b0);
        rd_chk(ADDR_LO1, 8'hE0, "prescale_lo");
        rd_chk(ADDR_HI1, 8'h00, "prescale_hi");
        ack_chk(1);
        $display("test prescaler done");
        // counter, gated: closed gate must block all edges
        wr_b(ADDR_MODE, 8'h0D);
        wr_b(ADDR_LO0, 8'hFE);
        wr_b(ADDR_HI0, 8'hFF);
        wr_bit(3'h4, 1'b1);
        pm0.pulses(3);
        repeat (24) @(negedge clk);
        rd_chk(ADDR_LO0, 8'hFE, "gate_closed");
        g0 = 1'b1;
        pm0.pulses(3);
        repeat (36) @(negedge clk);
        rd_chk(ADDR_LO0, 8'h01, "count_lo");
        rd_chk(ADDR_HI0, 8'h00, "count_hi");
        chk("count_flag", 8'h01, {7'h00, flag[0]});
        ack_chk(0);
        wr_bit(3'h4, 1'b0);
        // gate of timer 1 closed for the first edge, open for the next two
        wr_b(ADDR_MODE, 8'hD0);
        wr_b(ADDR_LO1, 8'h00);
        wr_bit(3'h6, 1'b1);
        pm1.pulses(1);
        g1 = 1'b1;
        pm1.pulses(2);
        repeat (36) @(negedge clk);
        wr_bit(3'h6, 1'b0);
        rd_chk(ADDR_LO1, 8'h02, "count_one");
        $display("test counter done");
        // split timer 0: high byte runs on timer 1 run bit, timer 1 held
        wr_b(ADDR_MODE, 8'h33);
        wr_b(ADDR_HI0, 8'hFF);
        wr_bit(3'h6, 1'b1);
        wait_pulse(1, 20, n);
        repeat (24) @(negedge clk);
        rd_chk(ADDR_LO1, 8'h02, "held");
        $display("test split done");
        complete_run();
    end
endmodule
